// ### tcs_consts.vh
`ifndef TCS_CONSTS_VH
`define TCS_CONSTS_VH

// Register map: one enable word and one status word per channel.
`define TCS_ADDR_W 8
`define TCS_CHAN_N 6
`define TCS_CHAN_STRIDE 8'h08
`define TCS_ENABLE_OFS 8'h00
`define TCS_STATUS_OFS 8'h04
`define TCS_MAP_END 8'h30

// Interrupt enable register fields.
`define TCS_EN_A_BIT 0
`define TCS_EN_B_BIT 1
`define TCS_EN_C_BIT 2
`define TCS_EN_RSV1_BIT 6
`define TCS_EN_OVF_BIT 4
`define TCS_EN_UNF_BIT 5
`define TCS_EN_RESET 8'h40

// Status register fields.
`define TCS_ST_A_BIT 0
`define TCS_ST_B_BIT 1
`define TCS_ST_C_BIT 2
`define TCS_ST_OVF_BIT 4
`define TCS_ST_UNF_BIT 5
`define TCS_ST_RSV1_BIT 6
`define TCS_ST_DIR_BIT 7
`define TCS_ST_RESET 8'hC0

// Channels that own compare C and lack underflow/direction (0 and 3).
`define TCS_CD_CHANS 6'h09

`endif

// ### tcs_flag.v
`timescale 1ns/1ns
`default_nettype none

// One event flag: set by hardware, cleared only by a 0 write after a read of 1.
module tcs_flag #(
  parameter PRESENT = 1
) (
  // Clock and reset
  input wire clock,
  input wire srst,
  // Event and bus strobes
  input wire set_evt,
  input wire rd_done,
  input wire wr_done,
  input wire wr_bit,
  // State
  output wire flag_nxt,
  output wire flag
);

  reg flag_r;
  reg armed_r;
  wire clr;

  assign clr = wr_done & ~wr_bit & armed_r;
  // A set in the clearing cycle wins, so no event is lost.
  assign flag_nxt = (PRESENT != 0) & (set_evt | (flag_r & ~clr));
  assign flag = flag_r;

  always @(posedge clock) begin
    if (srst) begin
      flag_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      if (rd_done && flag_r) begin
        armed_r <= 1'b1;
      end else if (wr_done || !flag_r) begin
        armed_r <= 1'b0;
      end
    end
  end

endmodule // tcs_flag

`default_nettype wire

// ### tcs_enable.v
`timescale 1ns/1ns
`default_nettype none
`include "tcs_consts.vh"

// Interrupt enable register of one channel, with per-channel reserved bits.
module tcs_enable #(
  parameter HAS_CD = 1
) (
  // Clock and reset
  input wire clock,
  input wire srst,
  // Write strobe
  input wire wr_done,
  input wire [7:0] wdata,
  // Register value
  output wire [7:0] en_nxt,
  output wire [7:0] en
);

  reg [7:0] en_r;
  wire [7:0] wmask;

  // Bit 2 is writable only in channels with compare C; bit 5 only in the others.
  assign wmask = (HAS_CD != 0) ? 8'h17 : 8'h33;
  assign en_nxt = wr_done ? ((wdata & wmask) | `TCS_EN_RESET) : en_r;
  assign en = en_r;

  always @(posedge clock) begin
    if (srst) begin
      en_r <= `TCS_EN_RESET;
    end else begin
      en_r <= en_nxt;
    end
  end

endmodule // tcs_enable

`default_nettype wire

// ### tcs_status_irq.v
`timescale 1ns/1ns
`default_nettype none
`include "tcs_consts.vh"

// Notes on behaviour
// - Channels 0 and 3: compare C request needs C flag and enable bit 2.
// - Channels 1, 2, 4, 5: enable bit 2 reads 0, writes ignored.
// - Compare B request needs B flag and enable bit 1, every channel.
// - Compare A request needs A flag and enable bit 0, every channel.
// - Enable bits C, B, A are read/write and reset to 0.
// - Each of six channels has its own status register.
// - Status bit 7 shows count direction; channels 0, 3 read 1; resets 1.
// - Status bit 6 always reads 1, writes ignored.
// - Underflow flag bit 5 sets on wrap 0000 to FFFF in phase counting.
// - Channels 0 and 3: status bit 5 reads 0, writes ignored.
// - Overflow flag bit 4 sets on wrap FFFF to 0000; resets 0.
// - Underflow flag clears by reading 1 then writing 0; 1 never sets.
// - Overflow flag clears by reading 1 then writing 0; 1 never sets.
// - Overflow request needs overflow flag and enable bit 4.
// - Channels 1, 2, 4, 5: underflow request needs flag and enable bit 5.
// - C flag sets on compare match or capture into compare register C.
module tcs_status_irq #(
  parameter CHAN_N = `TCS_CHAN_N
) (
  // Clock and reset
  input wire clock,
  input wire srst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`TCS_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Counter datapath events, one bit per channel, same clock
  input wire [CHAN_N-1:0] ovf_evt,
  input wire [CHAN_N-1:0] unf_evt,
  input wire [CHAN_N-1:0] phase_mode,
  input wire [CHAN_N-1:0] count_up,
  input wire [CHAN_N-1:0] cmp_c_evt,
  input wire [CHAN_N-1:0] cmp_b_evt,
  input wire [CHAN_N-1:0] cmp_a_evt,
  // Interrupt requests
  output reg [CHAN_N-1:0] cmp_c_irq,
  output reg [CHAN_N-1:0] cmp_b_irq,
  output reg [CHAN_N-1:0] cmp_a_irq,
  output reg [CHAN_N-1:0] overflow_irq,
  output reg [CHAN_N-1:0] underflow_irq
);

  wire access;
  wire done;
  wire aligned;
  wire in_map;
  wire [3:0] chan_sel;
  wire is_status;
  reg [CHAN_N-1:0] count_dir_flag_r;
  wire [7:0] enable_q [0:CHAN_N-1];
  wire [7:0] enable_n [0:CHAN_N-1];
  wire [7:0] status_q [0:CHAN_N-1];
  wire [CHAN_N-1:0] ovf_n;
  wire [CHAN_N-1:0] unf_n;
  wire [CHAN_N-1:0] c_n;
  wire [CHAN_N-1:0] b_n;
  wire [CHAN_N-1:0] a_n;
  reg [7:0] rd_byte;
  integer j;

  // One wait state: the answer is registered so every bus output is a flop.
  assign access = psel & penable;
  assign done = access & pready;
  assign aligned = (paddr[1:0] == 2'h0);
  assign in_map = aligned & (paddr < `TCS_MAP_END);
  assign chan_sel = paddr[6:3];
  assign is_status = paddr[2];

  genvar g;
  generate
    for (g = 0; g < CHAN_N; g = g + 1) begin : g_chan
      localparam HAS_CD = (`TCS_CD_CHANS >> g) & 1;
      wire sel;
      wire en_wr;
      wire st_wr;
      wire st_rd;
      wire ovf_q;
      wire unf_q;
      wire c_q;
      wire b_q;
      wire a_q;

      assign sel = done & in_map & (chan_sel == g);
      assign en_wr = sel & pwrite & ~is_status;
      assign st_wr = sel & pwrite & is_status;
      assign st_rd = sel & ~pwrite & is_status;

      tcs_enable #(.HAS_CD(HAS_CD)) u_enable (
        .clock(clock),
        .srst(srst),
        .wr_done(en_wr),
        .wdata(pwdata[7:0]),
        .en_nxt(enable_n[g]),
        .en(enable_q[g])
      );

      tcs_flag #(.PRESENT(1)) u_ovf (
        .clock(clock),
        .srst(srst),
        .set_evt(ovf_evt[g]),
        .rd_done(st_rd & prdata[`TCS_ST_OVF_BIT]),
        .wr_done(st_wr),
        .wr_bit(pwdata[`TCS_ST_OVF_BIT]),
        .flag_nxt(ovf_n[g]),
        .flag(ovf_q)
      );

      tcs_flag #(.PRESENT(1 - HAS_CD)) u_unf (
        .clock(clock),
        .srst(srst),
        .set_evt(unf_evt[g] & phase_mode[g]),
        .rd_done(st_rd & prdata[`TCS_ST_UNF_BIT]),
        .wr_done(st_wr),
        .wr_bit(pwdata[`TCS_ST_UNF_BIT]),
        .flag_nxt(unf_n[g]),
        .flag(unf_q)
      );

      tcs_flag #(.PRESENT(HAS_CD)) u_c (
        .clock(clock),
        .srst(srst),
        .set_evt(cmp_c_evt[g]),
        .rd_done(st_rd & prdata[`TCS_ST_C_BIT]),
        .wr_done(st_wr),
        .wr_bit(pwdata[`TCS_ST_C_BIT]),
        .flag_nxt(c_n[g]),
        .flag(c_q)
      );

      tcs_flag #(.PRESENT(1)) u_b (
        .clock(clock),
        .srst(srst),
        .set_evt(cmp_b_evt[g]),
        .rd_done(st_rd & prdata[`TCS_ST_B_BIT]),
        .wr_done(st_wr),
        .wr_bit(pwdata[`TCS_ST_B_BIT]),
        .flag_nxt(b_n[g]),
        .flag(b_q)
      );

      tcs_flag #(.PRESENT(1)) u_a (
        .clock(clock),
        .srst(srst),
        .set_evt(cmp_a_evt[g]),
        .rd_done(st_rd & prdata[`TCS_ST_A_BIT]),
        .wr_done(st_wr),
        .wr_bit(pwdata[`TCS_ST_A_BIT]),
        .flag_nxt(a_n[g]),
        .flag(a_q)
      );

      // Channels 0 and 3 count up only, so their direction bit is held at 1.
      assign status_q[g] = {(HAS_CD != 0) | count_dir_flag_r[g], 1'b1, unf_q, ovf_q, 1'b0, c_q, b_q, a_q};
    end
  endgenerate

  // Requests are registered from next-state values, so they equal flag AND
  // enable in every cycle while still coming straight from flip-flops.
  integer i;
  always @(posedge clock) begin
    if (srst) begin
      cmp_c_irq <= {CHAN_N{1'b0}};
      cmp_b_irq <= {CHAN_N{1'b0}};
      cmp_a_irq <= {CHAN_N{1'b0}};
      overflow_irq <= {CHAN_N{1'b0}};
      underflow_irq <= {CHAN_N{1'b0}};
      count_dir_flag_r <= {CHAN_N{1'b1}};
    end else begin
      count_dir_flag_r <= count_up;
      for (i = 0; i < CHAN_N; i = i + 1) begin
        cmp_c_irq[i] <= c_n[i] & enable_n[i][`TCS_EN_C_BIT];
        cmp_b_irq[i] <= b_n[i] & enable_n[i][`TCS_EN_B_BIT];
        cmp_a_irq[i] <= a_n[i] & enable_n[i][`TCS_EN_A_BIT];
        overflow_irq[i] <= ovf_n[i] & enable_n[i][`TCS_EN_OVF_BIT];
        underflow_irq[i] <= unf_n[i] & enable_n[i][`TCS_EN_UNF_BIT];
      end
    end
  end

  always @* begin
    rd_byte = 8'h00;
    for (j = 0; j < CHAN_N; j = j + 1) begin
      if (chan_sel == j) begin
        rd_byte = is_status ? status_q[j] : enable_q[j];
      end
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~in_map;
      if (access && !pready && !pwrite && in_map) begin
        prdata <= {24'h000000, rd_byte};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

endmodule // tcs_status_irq

`default_nettype wire

// ### tcs_status_irq_checker.sv
`timescale 1ns/1ns
`default_nettype none

module tcs_status_irq_checker #(
  parameter CHAN_N = 6
) (
  // Clock and reset
  input wire clock,
  input wire srst,
  // Bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Events and requests
  input wire [CHAN_N-1:0] ovf_evt,
  input wire [CHAN_N-1:0] unf_evt,
  input wire [CHAN_N-1:0] phase_mode,
  input wire [CHAN_N-1:0] cmp_c_irq,
  input wire [CHAN_N-1:0] cmp_a_irq,
  input wire [CHAN_N-1:0] overflow_irq,
  input wire [CHAN_N-1:0] underflow_irq
);
  // Channels 0 and 3 own compare C and lack underflow.
  localparam [CHAN_N-1:0] CD = 6'h09;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; !pready ##1 pready; endsequence
  property p_wait; s_setup |=> s_answer; endproperty
  a_wait: assert property (p_wait) else $error("answer not after one wait state");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside answer");
  property p_refuse; pready && (paddr >= 8'h30 || paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0; endproperty
  a_refuse: assert property (p_refuse) else $error("bad address not refused");
  property p_rsv; pready && !pwrite && !pslverr && paddr[2] |-> prdata[6] && !prdata[3] && prdata[31:8] == 24'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("status reserved bits wrong");
  property p_c_rsv; (cmp_c_irq & ~CD) == 6'h00; endproperty
  a_c_rsv: assert property (p_c_rsv) else $error("compare C request on wrong channel");
  property p_u_rsv; (underflow_irq & CD) == 6'h00; endproperty
  a_u_rsv: assert property (p_u_rsv) else $error("underflow request on wrong channel");
  property p_v_rise; (overflow_irq & ~$past(overflow_irq)) != 6'h00 |-> $past(|ovf_evt || (pready && pwrite)); endproperty
  a_v_rise: assert property (p_v_rise) else $error("overflow request without cause");
  property p_u_rise;
    (underflow_irq & ~$past(underflow_irq)) != 6'h00 |-> $past(|(unf_evt & phase_mode) || (pready && pwrite));
  endproperty
  a_u_rise: assert property (p_u_rise) else $error("underflow request without cause");
  property p_a_fall; ($past(cmp_a_irq) & ~cmp_a_irq) != 6'h00 |-> $past(pready && pwrite); endproperty
  a_a_fall: assert property (p_a_fall) else $error("compare A request fell without write");
endmodule // tcs_status_irq_checker

bind tcs_status_irq tcs_status_irq_checker #(.CHAN_N(CHAN_N)) tcs_chk (.clock(clock), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ovf_evt(ovf_evt), .unf_evt(unf_evt), .phase_mode(phase_mode), .cmp_c_irq(cmp_c_irq), .cmp_a_irq(cmp_a_irq),
  .overflow_irq(overflow_irq), .underflow_irq(underflow_irq));
`default_nettype wire

// ### tb_timer_channel_irq_status.sv
`timescale 1ns/1ns
`default_nettype none

module tb_timer_channel_irq_status;
  logic clock, srst, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [5:0] ovf_evt, unf_evt, phase_mode, count_up, c_evt, b_evt, a_evt, c_irq, b_irq, a_irq, v_irq, u_irq;
  int errors, n_tests;

  tcs_status_irq tcs_status_irq_i (.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ovf_evt(ovf_evt),
    .unf_evt(unf_evt), .phase_mode(phase_mode), .count_up(count_up), .cmp_c_evt(c_evt), .cmp_b_evt(b_evt),
    .cmp_a_evt(a_evt), .cmp_c_irq(c_irq), .cmp_b_irq(b_irq), .cmp_a_irq(a_irq), .overflow_irq(v_irq),
    .underflow_irq(u_irq));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  // The wait is bounded so a missing ready counts as a mismatch, not a hang.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) errors++;
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), {24'h0, e}, q);
  endtask

  task automatic irq(input logic [29:0] e);
    chk("irq", {2'h0, e}, {2'h0, c_irq, b_irq, a_irq, v_irq, u_irq});
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    repeat (4000) @(posedge clock);
    errors++;
    report_and_stop;
  end

  initial begin
    logic cd;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ovf_evt, unf_evt, c_evt, b_evt, a_evt} = '0;
    phase_mode = 6'h02;
    count_up = 6'h3F;
    srst = 1'b1;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    for (int ch = 0; ch < 6; ch++) begin
      rd(8'(32'h8 * ch), 8'h40);
      rd(8'(32'h8 * ch + 32'h4), 8'hC0);
    end
    $display("test reset values done");
    {ovf_evt, unf_evt, c_evt, b_evt, a_evt} <= {5{6'h3F}};
    @(posedge clock);
    {ovf_evt, unf_evt, c_evt, b_evt, a_evt} <= '0;
    @(posedge clock);
    irq(30'h0);
    count_up <= 6'h3D;
    for (int ch = 0; ch < 6; ch++) begin
      cd = ch == 0 || ch == 3;
      xfer(1'b1, 8'(32'h8 * ch), 8'hFF);
      rd(8'(32'h8 * ch), cd ? 8'h57 : 8'h73);
    end
    xfer(1'b1, 8'h24, 8'h00);
    irq({6'h09, 6'h3F, 6'h3F, 6'h3F, 6'h02});
    $display("test events done");
    for (int ch = 0; ch < 6; ch++) begin
      cd = ch == 0 || ch == 3;
      rd(8'(32'h8 * ch + 32'h4), cd ? 8'hD7 : (ch == 1 ? 8'h73 : 8'hD3));
    end
    xfer(1'b1, 8'h0C, 8'h00);
    xfer(1'b1, 8'h04, 8'hFF);
    irq({6'h09, 6'h3D, 6'h3D, 6'h3D, 6'h00});
    xfer(1'b1, 8'h00, 8'h00);
    irq({6'h08, 6'h3C, 6'h3C, 6'h3C, 6'h00});
    rd(8'h0C, 8'h40);
    $display("test clearing done");
    xfer(1'b0, 8'h30, 8'h00);
    chk("pslverr", 32'h1, {31'h0, perr});
    chk("prdata", 32'h0, q);
    xfer(1'b1, 8'h02, 8'hFF);
    chk("pslverr", 32'h1, {31'h0, perr});
    rd(8'h00, 8'h40);
    $display("test refused access done");
    report_and_stop;
  end
endmodule // tb_timer_channel_irq_status
`default_nettype wire
